// >>> dfacc_bus_partner.sv
`timescale 1ns/1ps
module dfacc_bus_partner (
  input  wire logic       i_clock,
  input  wire logic       i_reset,
  input  wire logic       i_bus_req,
  input  wire logic [3:0] i_wait,
  output logic            o_bus_grant,
  output logic            o_xfer_done
);
  logic [3:0] cnt_r;
  // Grant follows request, done pulse i_wait+1 cycles after grant rises
  always_ff @(posedge i_clock) begin
    if (i_reset || !i_bus_req) begin
      o_bus_grant <= 1'b0;
      o_xfer_done <= 1'b0;
      cnt_r       <= 4'h0;
    end else if (!o_bus_grant) begin
      o_bus_grant <= 1'b1;
    end else begin
      o_xfer_done <= (cnt_r == i_wait) && !o_xfer_done;
      cnt_r       <= o_xfer_done ? 4'h0 : cnt_r + 4'h1;
    end
  end
endmodule

// >>> dfacc_channel.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
module dfacc_channel (
  input  wire logic        i_clock,
  input  wire logic        i_reset,
  input  wire logic        i_standby,
  input  wire logic        i_nmi,
  input  wire logic [2:0]  i_addr,
  input  wire logic [23:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  input  wire logic        i_ext_req_n,
  input  wire logic [3:0]  i_timer_event,
  input  wire logic        i_timer_claimed,
  input  wire logic        i_bus_grant,
  input  wire logic        i_xfer_done,
  output logic [23:0]      o_rdata,
  output logic             o_bus_req,
  output logic [23:0]      o_xfer_src,
  output logic [23:0]      o_xfer_dst,
  output logic             o_xfer_word,
  output logic             o_end_irq,
  output logic             o_timer_taken
);
  logic [7:0]  ctrl_a_r;
  logic [7:0]  ctrl_b_r;
  logic [23:0] src_r;
  logic [23:0] dst_r;
  logic [15:0] count_a_r;
  logic [15:0] blk_count_r;
  logic        rd_a_zero_r;
  logic        rd_b_zero_r;
  logic        pend_r;
  logic        ext_s1_r;
  logic        ext_s2_r;
  logic        ext_prev_r;
  logic        end_irq_r;
  logic        end_seen_r;
  dfacc_pkg::dfacc_state_t state_r;
  dfacc_pkg::dfacc_bus_t   bus;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  logic        full_mode;
  logic        blk_mode;
  logic        active;
  logic        word;
  logic [2:0]  act;
  logic        usable;
  logic        auto_req;
  logic        trigger;
  logic        timer_hit;
  logic [23:0] step;
  logic        last_in_blk;
  logic        last_xfer;
  logic        xfer_end;
  logic        src_block;
  logic        dst_block;

  assign full_mode = ctrl_a_r[dfacc_pkg::BIT_SEL_HI] &
                     ctrl_a_r[dfacc_pkg::BIT_SEL_LO];
  assign blk_mode  = full_mode & ctrl_a_r[dfacc_pkg::BIT_BLK_MODE];
  assign active    = full_mode & ctrl_a_r[dfacc_pkg::BIT_ENABLE] &
                     ctrl_b_r[dfacc_pkg::BIT_ENABLE];
  assign word      = ctrl_a_r[dfacc_pkg::BIT_SIZE];
  assign act       = ctrl_b_r[2:0];
  assign step      = word ? dfacc_pkg::STEP_WORD
                          : dfacc_pkg::STEP_BYTE;
  assign src_block = blk_mode & ctrl_b_r[dfacc_pkg::BIT_BLK_AREA];
  assign dst_block = blk_mode & ~ctrl_b_r[dfacc_pkg::BIT_BLK_AREA];
  assign timer_hit = i_timer_event[act[1:0]] & ~i_timer_claimed;

  always_comb begin
    usable   = 1'b0;
    auto_req = 1'b0;
    trigger  = 1'b0;
    if (!blk_mode) begin
      case (act)
        dfacc_pkg::ACT_BURST: begin
          usable   = 1'b1;
          auto_req = 1'b1;
        end
        dfacc_pkg::ACT_STEAL: begin
          usable   = 1'b1;
          auto_req = 1'b1;
        end
        dfacc_pkg::ACT_EXTERNAL_REQUEST_IN_FALL: begin
          usable  = 1'b1;
          trigger = ext_prev_r & ~ext_s2_r;
        end
        dfacc_pkg::ACT_EXTERNAL_REQUEST_IN_LOW: begin
          usable  = 1'b1;
          trigger = ~ext_s2_r;
        end
        default: usable = 1'b0;
      endcase
    end else begin
      if (act <= dfacc_pkg::ACT_TIMER_MAX) begin
        usable  = 1'b1;
        trigger = timer_hit;
      end else if (act == dfacc_pkg::ACT_EXTERNAL_REQUEST_IN_FALL) begin
        usable  = 1'b1;
        trigger = ext_prev_r & ~ext_s2_r;
      end
    end
  end

  assign last_in_blk = (count_a_r[15:8] == 8'h01);
  assign last_xfer   = blk_mode ? (last_in_blk && blk_count_r == 16'h0001)
                                : (count_a_r == 16'h0001);
  assign xfer_end    = (state_r == dfacc_pkg::ST_XFER) & i_xfer_done;

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      ext_s1_r   <= 1'b1;
      ext_s2_r   <= 1'b1;
      ext_prev_r <= 1'b1;
    end else begin
      ext_s1_r   <= i_ext_req_n;
      ext_s2_r   <= ext_s1_r;
      ext_prev_r <= ext_s2_r;
    end
  end

  // Pending request latch
  always_ff @(posedge i_clock) begin
    if (i_reset || !active || !usable) begin
      pend_r <= 1'b0;
    end else if (trigger) begin
      pend_r <= 1'b1;
    end else if (state_r == dfacc_pkg::ST_REQ && i_bus_grant &&
                 !(blk_mode && !last_in_blk)) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      state_r       <= dfacc_pkg::ST_IDLE;
      o_bus_req     <= 1'b0;
      o_timer_taken <= 1'b0;
    end else begin
      o_timer_taken <= blk_mode && active && usable && timer_hit &&
                       act <= dfacc_pkg::ACT_TIMER_MAX;
      case (state_r)
        dfacc_pkg::ST_IDLE: begin
          if (active && usable && (auto_req || pend_r)) begin
            state_r   <= dfacc_pkg::ST_REQ;
            o_bus_req <= 1'b1;
          end
        end
        dfacc_pkg::ST_REQ: begin
          if (!active) begin
            state_r   <= dfacc_pkg::ST_IDLE;
            o_bus_req <= 1'b0;
          end else if (i_bus_grant) begin
            state_r <= dfacc_pkg::ST_XFER;
          end
        end
        dfacc_pkg::ST_XFER: begin
          if (i_xfer_done) begin
            if (last_xfer || !active ||
                (!blk_mode && act == dfacc_pkg::ACT_STEAL)) begin
              state_r   <= dfacc_pkg::ST_IDLE;
              o_bus_req <= 1'b0;
            end else if (!blk_mode && act == dfacc_pkg::ACT_BURST) begin
              state_r <= dfacc_pkg::ST_REQ;
            end else if (blk_mode && !last_in_blk) begin
              state_r <= dfacc_pkg::ST_REQ;
            end else begin
              state_r   <= dfacc_pkg::ST_IDLE;
              o_bus_req <= 1'b0;
            end
          end
        end
        default: begin
          state_r   <= dfacc_pkg::ST_IDLE;
          o_bus_req <= 1'b0;
        end
      endcase
    end
  end

  // Control A and channel enable
  always_ff @(posedge i_clock) begin
    if (i_reset || i_standby) begin
      ctrl_a_r    <= dfacc_pkg::CTRL_RESET;
      rd_a_zero_r <= 1'b0;
    end else begin
      if (bus.rd && bus.addr == dfacc_pkg::REG_CTRL_A) begin
        rd_a_zero_r <= ~ctrl_a_r[dfacc_pkg::BIT_ENABLE];
      end
      if (bus.wr && bus.addr == dfacc_pkg::REG_CTRL_A) begin
        ctrl_a_r[6:0] <= bus.wdata[6:0];
        rd_a_zero_r   <= 1'b0;
        ctrl_a_r[dfacc_pkg::BIT_ENABLE] <= bus.wdata[dfacc_pkg::BIT_ENABLE] &
          (ctrl_a_r[dfacc_pkg::BIT_ENABLE] | rd_a_zero_r);
      end
      if (xfer_end && last_xfer) begin
        ctrl_a_r[dfacc_pkg::BIT_ENABLE] <= 1'b0;
      end
    end
  end

  // Control B and master enable
  always_ff @(posedge i_clock) begin
    if (i_reset || i_standby) begin
      ctrl_b_r    <= dfacc_pkg::CTRL_RESET;
      rd_b_zero_r <= 1'b0;
    end else begin
      if (bus.rd && bus.addr == dfacc_pkg::REG_CTRL_B) begin
        rd_b_zero_r <= ~ctrl_b_r[dfacc_pkg::BIT_ENABLE];
      end
      if (bus.wr && bus.addr == dfacc_pkg::REG_CTRL_B) begin
        ctrl_b_r[6:0] <= bus.wdata[6:0];
        rd_b_zero_r   <= 1'b0;
        ctrl_b_r[dfacc_pkg::BIT_ENABLE] <= bus.wdata[dfacc_pkg::BIT_ENABLE] &
          (ctrl_b_r[dfacc_pkg::BIT_ENABLE] | rd_b_zero_r);
      end
      if (i_nmi) begin
        ctrl_b_r[dfacc_pkg::BIT_ENABLE] <= 1'b0;
      end
    end
  end

  // Addresses and counters
  always_ff @(posedge i_clock) begin
    if (bus.wr && bus.addr == dfacc_pkg::REG_SRC_ADDR) begin
      src_r <= bus.wdata;
    end else if (xfer_end && ctrl_a_r[dfacc_pkg::BIT_STEP_EN]) begin
      src_r <= ctrl_a_r[dfacc_pkg::BIT_STEP_DIR] ? src_r - step
                                                 : src_r + step;
    end
    if (bus.wr && bus.addr == dfacc_pkg::REG_DST_ADDR) begin
      dst_r <= bus.wdata;
    end else if (xfer_end && ctrl_b_r[dfacc_pkg::BIT_STEP_EN]) begin
      dst_r <= ctrl_b_r[dfacc_pkg::BIT_STEP_DIR] ? dst_r - step
                                                 : dst_r + step;
    end
    if (bus.wr && bus.addr == dfacc_pkg::REG_COUNT_A) begin
      count_a_r <= bus.wdata[15:0];
    end else if (xfer_end && !blk_mode) begin
      count_a_r <= count_a_r - 16'h0001;
    end else if (xfer_end) begin
      count_a_r[15:8] <= last_in_blk ? count_a_r[7:0]
                                     : count_a_r[15:8] - 8'h01;
    end
    if (bus.wr && bus.addr == dfacc_pkg::REG_BLK_COUNT) begin
      blk_count_r <= bus.wdata[15:0];
    end else if (xfer_end && blk_mode && last_in_blk) begin
      blk_count_r <= blk_count_r - 16'h0001;
    end
  end

  // End interrupt on enable falling
  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      end_seen_r <= 1'b0;
      end_irq_r  <= 1'b0;
      o_end_irq  <= 1'b0;
    end else begin
      end_seen_r <= ctrl_a_r[dfacc_pkg::BIT_ENABLE];
      if (end_seen_r && !ctrl_a_r[dfacc_pkg::BIT_ENABLE] &&
          ctrl_a_r[dfacc_pkg::BIT_IRQ_EN]) begin
        end_irq_r <= 1'b1;
      end else if (ctrl_a_r[dfacc_pkg::BIT_ENABLE] ||
                   !ctrl_a_r[dfacc_pkg::BIT_IRQ_EN]) begin
        end_irq_r <= 1'b0;
      end
      o_end_irq <= end_irq_r;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_reset) begin
      o_rdata     <= 24'h000000;
      o_xfer_src  <= 24'h000000;
      o_xfer_dst  <= 24'h000000;
      o_xfer_word <= 1'b0;
    end else begin
      o_xfer_src  <= src_r;
      o_xfer_dst  <= dst_r;
      o_xfer_word <= word;
      o_rdata     <= 24'h000000;
      if (bus.rd) begin
        case (bus.addr)
          dfacc_pkg::REG_CTRL_A:    o_rdata <= {16'h0000, ctrl_a_r};
          dfacc_pkg::REG_CTRL_B:    o_rdata <= {16'h0000, ctrl_b_r};
          dfacc_pkg::REG_SRC_ADDR:  o_rdata <= src_r;
          dfacc_pkg::REG_DST_ADDR:  o_rdata <= dst_r;
          dfacc_pkg::REG_COUNT_A:   o_rdata <= {8'h00, count_a_r};
          dfacc_pkg::REG_BLK_COUNT: o_rdata <= {8'h00, blk_count_r};
          dfacc_pkg::REG_STATUS:
            o_rdata <= {18'h00000, src_block, dst_block, state_r,
                        active, pend_r};
          default:                  o_rdata <= 24'h000000;
        endcase
      end
    end
  end
endmodule

// >>> dfacc_channel_properties.sv
`timescale 1ns/1ps
module dfacc_checker (
  input wire logic        i_clock,
  input wire logic        i_reset,
  input wire logic        i_standby,
  input wire logic        i_nmi,
  input wire logic [2:0]  i_addr,
  input wire logic [23:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [23:0] o_rdata,
  input wire logic        o_bus_req,
  input wire logic [23:0] o_xfer_src,
  input wire logic [23:0] o_xfer_dst,
  input wire logic        o_end_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_reset);
  function automatic logic step_ok(input logic [23:0] d);
    return d == 24'h000001 || d == 24'h000002 ||
           d == 24'hffffff || d == 24'hfffffe;
  endfunction
  property p_src_step;
    !$past(i_reset) && !$past(i_reset, 2) && !$past(i_wr) &&
    !$past(i_wr, 2) && o_xfer_src != $past(o_xfer_src)
    |-> step_ok(o_xfer_src - $past(o_xfer_src));
  endproperty
  property p_dst_step;
    !$past(i_reset) && !$past(i_reset, 2) && !$past(i_wr) &&
    !$past(i_wr, 2) && o_xfer_dst != $past(o_xfer_dst)
    |-> step_ok(o_xfer_dst - $past(o_xfer_dst));
  endproperty
  property p_irq_hold;
    o_end_irq && !i_wr && !$past(i_wr) && !$past(i_wr, 2) && !i_standby &&
    !$past(i_standby) && !$past(i_standby, 2) |=> o_end_irq;
  endproperty
  property p_nmi_read;
    i_nmi ##1 (i_rd && i_addr == dfacc_pkg::REG_CTRL_B) |=> !o_rdata[7];
  endproperty
  property p_std_read;
    i_standby ##1 (i_rd && i_addr == dfacc_pkg::REG_CTRL_B)
    |=> o_rdata[7:0] == 8'h00;
  endproperty
  property p_resv;
    i_wr && !i_standby && i_addr == dfacc_pkg::REG_CTRL_B
    ##1 !i_wr && !i_standby
    ##1 (i_rd && i_addr == dfacc_pkg::REG_CTRL_B)
    |=> o_rdata[6] == $past(i_wdata[6], 3);
  endproperty
  property p_nmi_drop;
    i_nmi |-> ##[1:16] !o_bus_req;
  endproperty
  property p_rose_req;
    $rose(o_bus_req) |-> !$past(i_standby, 2) && !$past(i_nmi, 2);
  endproperty
  a_src_step: assert property (p_src_step)
    else $error("source address step wrong");
  a_dst_step: assert property (p_dst_step)
    else $error("destination address step wrong");
  a_irq_hold: assert property (p_irq_hold)
    else $error("end interrupt dropped on its own");
  a_nmi_read: assert property (p_nmi_read)
    else $error("master enable survived nmi");
  a_std_read: assert property (p_std_read)
    else $error("control b not cleared by standby");
  a_resv: assert property (p_resv)
    else $error("reserved bit not stored");
  a_nmi_drop: assert property (p_nmi_drop)
    else $error("bus request held after nmi");
  a_rose_req: assert property (p_rose_req)
    else $error("bus request while disabled");
  c_irq: cover property (o_end_irq);
  c_req: cover property ($rose(o_bus_req));
  c_nmi: cover property (i_nmi && o_bus_req);
endmodule
bind dfacc_channel dfacc_checker chk_i (.*);

// >>> dfacc_pkg.sv
package dfacc_pkg;
  localparam logic [2:0] REG_CTRL_A     = 3'h0;
  localparam logic [2:0] REG_CTRL_B     = 3'h1;
  localparam logic [2:0] REG_SRC_ADDR   = 3'h2;
  localparam logic [2:0] REG_DST_ADDR   = 3'h3;
  localparam logic [2:0] REG_COUNT_A    = 3'h4;
  localparam logic [2:0] REG_BLK_COUNT  = 3'h5;
  localparam logic [2:0] REG_STATUS     = 3'h6;
  localparam int         BIT_ENABLE     = 7;
  localparam int         BIT_SIZE       = 6;
  localparam int         BIT_STEP_DIR   = 5;
  localparam int         BIT_STEP_EN    = 4;
  localparam int         BIT_IRQ_EN     = 3;
  localparam int         BIT_BLK_AREA   = 3;
  localparam int         BIT_SEL_HI     = 2;
  localparam int         BIT_SEL_LO     = 1;
  localparam int         BIT_BLK_MODE   = 0;
  localparam logic [7:0]  CTRL_RESET    = 8'h00;
  localparam logic [23:0] STEP_BYTE     = 24'h000001;
  localparam logic [23:0] STEP_WORD     = 24'h000002;
  localparam logic [2:0] ACT_BURST      = 3'h0;
  localparam logic [2:0] ACT_STEAL      = 3'h2;
  localparam logic [2:0] ACT_EXTERNAL_REQUEST_IN_FALL  = 3'h6;
  localparam logic [2:0] ACT_EXTERNAL_REQUEST_IN_LOW   = 3'h7;
  localparam logic [2:0] ACT_TIMER_MAX  = 3'h3;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_REQ   = 2'b01,
    ST_XFER  = 2'b10
  } dfacc_state_t;

  typedef struct packed {
    logic [2:0]  addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } dfacc_bus_t;
endpackage

// >>> dma_full_address_channel_control_tb.sv
`timescale 1ns/1ps
module dma_full_address_channel_control_tb;
  logic        i_clock, i_reset, i_standby, i_nmi, i_wr, i_rd;
  logic [2:0]  i_addr;
  logic [23:0] i_wdata, o_rdata, o_xfer_src, o_xfer_dst, rv;
  logic        grant, done, o_bus_req, o_end_irq;
  logic        ext_n, tclaim, xword, ttaken;
  logic [3:0]  wait_r, tev;
  int          num_errors, n_compared;
  logic [7:0]  bad_a [6] = '{8'h86, 8'h86, 8'h86, 8'h86, 8'h82, 8'h84};
  logic [7:0]  bad_b [6] = '{8'h81, 8'h83, 8'h84, 8'h85, 8'h80, 8'h80};
  dfacc_channel uut (.i_clock(i_clock), .i_reset(i_reset),
    .i_standby(i_standby), .i_nmi(i_nmi), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_ext_req_n(ext_n),
    .i_timer_event(tev), .i_timer_claimed(tclaim), .i_bus_grant(grant),
    .i_xfer_done(done), .o_rdata(o_rdata), .o_bus_req(o_bus_req),
    .o_xfer_src(o_xfer_src), .o_xfer_dst(o_xfer_dst), .o_xfer_word(xword),
    .o_end_irq(o_end_irq), .o_timer_taken(ttaken));
  dfacc_bus_partner partner (.i_clock(i_clock), .i_reset(i_reset),
    .i_bus_req(o_bus_req), .i_wait(wait_r), .o_bus_grant(grant),
    .o_xfer_done(done));
  task automatic summarize;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [23:0] d);
    @(posedge i_clock);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a);
    @(posedge i_clock);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clock);
    i_rd <= 1'b0;
    #1 rv = o_rdata;
  endtask
  task automatic chk(input string s, input logic [23:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("unexpected %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic rdc(input string s, input logic [2:0] a, logic [23:0] e);
    rd(a);
    chk(s, e, rv);
  endtask
  // Clear, read back zero, then set
  task automatic arm(input logic [2:0] r, input logic [7:0] v);
    wr(r, 24'h000000);
    rdc("armed", r, 24'h000000);
    wr(r, {16'h0000, v});
  endtask
  task automatic run(input logic [7:0] a, b, input logic [23:0] n, s0, d0,
                     s1, d1, input logic [3:0] w, input logic nmi);
    int k;
    wait_r = w;
    wr(dfacc_pkg::REG_SRC_ADDR, s0);
    wr(dfacc_pkg::REG_DST_ADDR, d0);
    wr(dfacc_pkg::REG_COUNT_A, n);
    arm(dfacc_pkg::REG_CTRL_B, b);
    arm(dfacc_pkg::REG_CTRL_A, a);
    if (nmi) begin
      repeat (6) @(posedge i_clock);
      i_nmi <= 1'b1;
      rdc("ctrl_b", dfacc_pkg::REG_CTRL_B, {16'h0, b & 8'h7f});
      i_nmi <= 1'b0;
      repeat (20) @(posedge i_clock);
      #1 chk("bus_req", 24'h0, {23'h0, o_bus_req});
      wr(dfacc_pkg::REG_CTRL_B, {16'h0, b});
    end
    for (k = 0; k < 300; k++) begin
      rd(dfacc_pkg::REG_CTRL_A);
      if (rv[7] === 1'b0) break;
    end
    if (k == 300) begin
      num_errors++;
      summarize();
    end
    rdc("ctrl_a", dfacc_pkg::REG_CTRL_A, {16'h0, a & 8'h7f});
    rdc("src", dfacc_pkg::REG_SRC_ADDR, s1);
    rdc("dst", dfacc_pkg::REG_DST_ADDR, d1);
    rd(dfacc_pkg::REG_COUNT_A);
    chk("count", 24'h0, {8'h0, rv[15:0]});
    repeat (3) @(posedge i_clock);
    #1 chk("end_irq", {23'h0, a[3]}, {23'h0, o_end_irq});
  endtask
  initial begin
    i_clock = 1'b0;
    forever #10 i_clock = ~i_clock;
  end
  initial begin
    {i_reset, i_standby, i_nmi, i_wr, i_rd} = 5'h10;
    {ext_n, tclaim, tev} = 6'h20;
    i_addr = 3'h0;
    i_wdata = 24'h000000;
    wait_r = 4'h0;
    num_errors = 0;
    n_compared = 0;
    repeat (16) @(posedge i_clock);
    i_reset <= 1'b0;
    wr(dfacc_pkg::REG_CTRL_B, 24'h000080);
    rdc("ctrl_b", dfacc_pkg::REG_CTRL_B, 24'h000000);
    wr(dfacc_pkg::REG_CTRL_B, 24'h0000c0);
    rdc("ctrl_b", dfacc_pkg::REG_CTRL_B, 24'h0000c0);
    wr(3'h7, 24'h00005a);
    rdc("unmapped", 3'h7, 24'h000000);
    i_standby <= 1'b1;
    rdc("ctrl_b", dfacc_pkg::REG_CTRL_B, 24'h000000);
    i_standby <= 1'b0;
    for (int j = 0; j < 6; j++) begin
      wr(dfacc_pkg::REG_CTRL_A, 24'h000000);
      arm(dfacc_pkg::REG_CTRL_B, bad_b[j]);
      arm(dfacc_pkg::REG_CTRL_A, bad_a[j]);
      repeat (20) begin
        @(posedge i_clock);
        #1 chk("idle_req", 24'h0, {23'h0, o_bus_req});
      end
    end
    run(8'hde, 8'h90, 24'h3, 24'h100, 24'h200, 24'h106, 24'h206, 4'h0,
        1'b0);
    run(8'hb6, 8'hb2, 24'h4, 24'h10, 24'h20, 24'h0c, 24'h1c, 4'h3,
        1'b1);
    run(8'h8e, 8'h80, 24'h2, 24'h40, 24'h50, 24'h40, 24'h50, 4'h1,
        1'b0);
    // External request held low, one transfer per request
    @(posedge i_clock);
    ext_n <= 1'b0;
    run(8'h9e, 8'h87, 24'h2, 24'h500, 24'h600, 24'h502, 24'h600, 4'h0,
        1'b0);
    ext_n <= 1'b1;
    // Block mode on timer channel 1, two blocks of two words
    wr(dfacc_pkg::REG_SRC_ADDR, 24'h000300);
    wr(dfacc_pkg::REG_DST_ADDR, 24'h000400);
    wr(dfacc_pkg::REG_COUNT_A, 24'h000202);
    wr(dfacc_pkg::REG_BLK_COUNT, 24'h000002);
    arm(dfacc_pkg::REG_CTRL_B, 8'h81);
    arm(dfacc_pkg::REG_CTRL_A, 8'hdf);
    for (int j = 0; j < 3; j++) begin
      @(posedge i_clock);
      {tclaim, tev} <= (j == 0) ? 5'h12 : 5'h02;
      @(posedge i_clock);
      {tclaim, tev} <= 5'h00;
      #1 chk("taken", 24'(j != 0), {23'h0, ttaken});
      repeat (20) @(posedge i_clock);
      rdc("src", dfacc_pkg::REG_SRC_ADDR, 24'h300 + 24'(4 * j));
      rdc("status", dfacc_pkg::REG_STATUS,
          (j == 2) ? 24'h10 : 24'h12);
    end
    rdc("ctrl_a", dfacc_pkg::REG_CTRL_A, 24'h00005f);
    rdc("blocks", dfacc_pkg::REG_BLK_COUNT, 24'h000000);
    rdc("size", dfacc_pkg::REG_COUNT_A, 24'h000202);
    rdc("dst", dfacc_pkg::REG_DST_ADDR, 24'h000400);
    chk("word", 24'h1, {23'h0, xword});
    chk("end_irq", 24'h1, {23'h0, o_end_irq});
    summarize();
  end
endmodule
